// *** dv/test_pao_top.sv ***
// self-checking bench of the phase accumulator oscillator
`timescale 1ns/1ps
`include "pao_defs.svh"
module test_pao_top;
  logic        sys_clk_i;
  logic        rstn_i;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i;
  logic        hwrite_i;
  logic [31:0] hwdata_i;
  logic [15:0] src_clk_i;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        nco_out_o;
  logic        irq_o;
  logic        keep_fast_osc_o;
  logic        rd_phase;
  logic [31:0] exp_q[$];
  logic [19:0] step_r;
  logic [19:0] acc_exp;
  int          fail_count;
  int          tests_run;
  int          n_hi;

  pao_top dut (
    .sys_clk_i       (sys_clk_i),
    .rstn_i          (rstn_i),
    .hsel_i          (hsel_i),
    .haddr_i         (haddr_i),
    .htrans_i        (htrans_i),
    .hwrite_i        (hwrite_i),
    .hsize_i         (hsize_i),
    .hwdata_i        (hwdata_i),
    .hready_i        (hreadyout_o),
    .src_clk_i       (src_clk_i),
    .hrdata_o        (hrdata_o),
    .hreadyout_o     (hreadyout_o),
    .hresp_o         (hresp_o),
    .nco_out_o       (nco_out_o),
    .irq_o           (irq_o),
    .keep_fast_osc_o (keep_fast_osc_o)
  );

  // ****************************************
  // clock, watchdog, closing
  // ****************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #400000;
    fail_count++;
    end_sim();
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // read data monitor: oldest note against the data phase result
  always @(posedge sys_clk_i) begin
    if (rd_phase && hreadyout_o === 1'b1) begin
      chk(hrdata_o, exp_q.pop_front());
    end
  end

  // ****************************************
  // bus master
  // ****************************************
  function automatic logic [31:0] adr(input logic [10:0] idx);
    return {19'h0, idx, 2'h0};
  endfunction : adr

  task automatic ahb(input logic wr, input logic [10:0] idx, input logic [31:0] d);
    htrans_i <= 2'h2;
    haddr_i  <= adr(idx);
    hwrite_i <= wr;
    hsize_i  <= 3'h2;
    hsel_i   <= 1'b1;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    if (!wr) begin
      exp_q.push_back(d);
      rd_phase <= 1'b1;
    end
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    rd_phase <= 1'b0;
  endtask : ahb

  task automatic count_high(output int n);
    n = 0;
    repeat (64) begin
      @(posedge sys_clk_i);
      if (nco_out_o === 1'b1) n++;
    end
  endtask : count_high

  task automatic step_set(input logic [19:0] s);
    ahb(1'b1, `PAO_IDX_INCU, {28'h0, s[19:16]});
    ahb(1'b1, `PAO_IDX_INCH, {24'h0, s[15:8]});
    ahb(1'b1, `PAO_IDX_INCL, {24'h0, s[7:0]});
  endtask : step_set

  task automatic src_pulses(input int k);
    repeat (k) begin
      src_clk_i[1] <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      src_clk_i[1] <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask : src_pulses

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn_i = 1'b0; hsel_i = 1'b0; haddr_i = 32'h0; htrans_i = 2'h0;
    hwrite_i = 1'b0; hwdata_i = 32'h0; src_clk_i = 16'h0; rd_phase = 1'b0;
    hsize_i = 3'h2;
    fail_count = 0;
    tests_run = 0;
    void'($urandom(32'hF3C2));
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    // reset values and unmapped place
    for (int i = 0; i < 10; i++) ahb(1'b0, 11'h58C + 11'(i), 32'h0);
    chk({31'h0, hresp_o}, 32'h0);
    // byte access, read-only output bit
    ahb(1'b1, `PAO_IDX_INCU, 32'h0000_00FF);
    ahb(1'b0, `PAO_IDX_INCU, 32'h0000_000F);
    ahb(1'b1, `PAO_IDX_INCH, 32'h0000_00A5);
    ahb(1'b0, `PAO_IDX_INCH, 32'h0000_00A5);
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0021);
    ahb(1'b0, `PAO_IDX_CON, 32'h0000_0001);
    ahb(1'b1, `PAO_IDX_CLK, 32'h0000_00E5);
    ahb(1'b0, `PAO_IDX_CLK, 32'h0000_00E5);
    // accumulator sum over five selected-source edges
    step_r = 20'($urandom) | 20'h00001;
    ahb(1'b1, `PAO_IDX_CLK, 32'h0000_0001);
    ahb(1'b1, `PAO_IDX_ACCL, 32'h0000_00F0);
    ahb(1'b1, `PAO_IDX_ACCH, 32'h0000_00FF);
    ahb(1'b1, `PAO_IDX_ACCU, 32'h0000_000F);
    step_set(step_r);
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0080);
    repeat (2) @(posedge sys_clk_i);
    chk({31'h0, keep_fast_osc_o}, 32'h1);
    src_pulses(5);
    repeat (6) @(posedge sys_clk_i);
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0000);
    acc_exp = 20'hFFFF0 + 20'(step_r * 5);
    ahb(1'b0, `PAO_IDX_ACCL, {24'h0, acc_exp[7:0]});
    ahb(1'b0, `PAO_IDX_ACCH, {24'h0, acc_exp[15:8]});
    ahb(1'b0, `PAO_IDX_ACCU, {28'h0, acc_exp[19:16]});
    // pulse widths, overflow every 16 system cycles
    step_set(20'h10000);
    ahb(1'b1, `PAO_IDX_IRQ, 32'h0000_0002);
    for (int w = 0; w < 8; w++) begin
      if (w == 4) continue;
      ahb(1'b1, `PAO_IDX_CLK, {24'h0, 3'(w), 5'h00});
      ahb(1'b1, `PAO_IDX_CON, 32'h0000_0081);
      repeat (40) @(posedge sys_clk_i);
      count_high(n_hi);
      chk(32'(n_hi), (w < 4) ? 32'(4 << w) : 32'h40);
    end
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0080);
    repeat (40) @(posedge sys_clk_i);
    count_high(n_hi);
    chk(32'(n_hi), 32'h20);
    chk({31'h0, irq_o}, 32'h1);
    ahb(1'b1, `PAO_IDX_CLK, 32'h0000_0000);
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0091);
    repeat (40) @(posedge sys_clk_i);
    count_high(n_hi);
    chk(32'(n_hi), 32'h3C);
    // disable, flag clear
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0000);
    repeat (4) @(posedge sys_clk_i);
    chk({30'h0, nco_out_o, irq_o}, 32'h0);
    ahb(1'b0, `PAO_IDX_IRQ, 32'h0000_0003);
    ahb(1'b1, `PAO_IDX_IRQ, 32'h0000_0002);
    ahb(1'b0, `PAO_IDX_IRQ, 32'h0000_0002);
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0010);
    repeat (4) @(posedge sys_clk_i);
    chk({31'h0, nco_out_o}, 32'h1);
    // polarity change while enabled, no overflow possible
    step_set(20'h00000);
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0080);
    repeat (8) @(posedge sys_clk_i);
    ahb(1'b0, `PAO_IDX_IRQ, 32'h0000_0002);
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0090);
    repeat (4) @(posedge sys_clk_i);
    ahb(1'b0, `PAO_IDX_IRQ, 32'h0000_0003);
    repeat (4) @(posedge sys_clk_i);
    // step change while running: old step for two edges, new on the third
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0000);
    ahb(1'b1, `PAO_IDX_CLK, 32'h0000_0001);
    ahb(1'b1, `PAO_IDX_ACCL, 32'h0000_0000);
    ahb(1'b1, `PAO_IDX_ACCH, 32'h0000_0000);
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0080);
    step_set(20'h00100);
    src_pulses(3);
    ahb(1'b1, `PAO_IDX_CON, 32'h0000_0000);
    ahb(1'b0, `PAO_IDX_ACCH, 32'h0000_0001);
    ahb(1'b0, `PAO_IDX_ACCL, 32'h0000_0000);
    end_sim();
  end
endmodule : test_pao_top

// *** hdl/pao_core_if.sv ***
// signals shared between the accumulator hub, clock edge picker and output shaper
`timescale 1ns/1ps
interface pao_core_if;
  logic       tick;
  logic       carry;
  logic       en;
  logic       pulse_mode;
  logic       output_invert;
  logic [2:0] pulse_width_sel;
  logic [3:0] clock_source_sel;
  logic       out_lvl;
  modport hub    (output carry, en, pulse_mode, output_invert, pulse_width_sel, clock_source_sel, input tick, out_lvl);
  modport edger  (input clock_source_sel, output tick);
  modport shaper (input tick, carry, en, pulse_mode, output_invert, pulse_width_sel, output out_lvl);
endinterface : pao_core_if

// *** hdl/pao_defs.svh ***
// register indices, field positions and constants of the phase accumulator oscillator
`ifndef PAO_DEFS_SVH
`define PAO_DEFS_SVH
// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define PAO_IDX_ACCL      11'h58C
`define PAO_IDX_ACCH      11'h58D
`define PAO_IDX_ACCU      11'h58E
`define PAO_IDX_INCL      11'h58F
`define PAO_IDX_INCH      11'h590
`define PAO_IDX_INCU      11'h591
`define PAO_IDX_CON       11'h592
`define PAO_IDX_CLK       11'h593
`define PAO_IDX_IRQ       11'h594
`define PAO_ADDR_HI       12
`define PAO_ADDR_LO       2
// ****************************************
// field positions
// ****************************************
`define PAO_CON_EN        7
`define PAO_CON_OUT       5
`define PAO_CON_POL       4
`define PAO_CON_PFM       0
`define PAO_CLK_PWS       7:5
`define PAO_CLK_CKS       3:0
`define PAO_IRQ_FLAG      0
`define PAO_IRQ_ENA       1
`define PAO_BYTE          7:0
`define PAO_NIB           3:0
`define PAO_ACC_LO        7:0
`define PAO_ACC_MID       15:8
`define PAO_ACC_UP        19:16
// ****************************************
// codes and counts
// ****************************************
`define PAO_CKS_SYS       4'h0
`define PAO_CKS_FAST      4'h1
`define PAO_CKS_RSV_A     4'hA
`define PAO_CKS_RSV_B     4'hF
`define PAO_ARM_WRITE     2'h2
`define PAO_ARM_LAST      2'h1
`define PAO_ARM_IDLE      2'h0
`define PAO_CNT_ONE       8'h01
`define PAO_RDATA_ZERO    32'h0000_0000
`endif

// *** hdl/pao_edge_pick.sv ***
// clock source synchroniser and selected-edge tick generator
`timescale 1ns/1ps
`include "pao_defs.svh"
module pao_edge_pick (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] src_clk_i,
  pao_core_if.edger        cif
);
  pao_pkg::pao_edge_t r;
  pao_pkg::pao_edge_t n;
  // ****************************************
  // sync, select, rising edge
  // ****************************************
  always_comb begin
    n      = r;
    n.s1   = src_clk_i;
    n.s2   = r.s1;
    n.prev = r.s2[cif.clock_source_sel];
    if (cif.clock_source_sel == `PAO_CKS_SYS) begin
      n.tick = 1'b1;
    end else if (cif.clock_source_sel == `PAO_CKS_RSV_A || cif.clock_source_sel == `PAO_CKS_RSV_B) begin
      n.tick = 1'b0;
    end else begin
      n.tick = r.s2[cif.clock_source_sel] & ~r.prev;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign cif.tick = r.tick;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_sys_tick;
    (cif.clock_source_sel == `PAO_CKS_SYS) |=> cif.tick;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("system clock source gave no tick");
  property p_rsv_tick;
    (cif.clock_source_sel == `PAO_CKS_RSV_B) |=> !cif.tick;
  endproperty
  a_rsv_tick: assert property (p_rsv_tick) else $error("reserved source produced a tick");
endmodule : pao_edge_pick

// *** hdl/pao_pkg.sv ***
// state types of the phase accumulator oscillator
package pao_pkg;
  typedef struct packed {
    logic [19:0] acc;
    logic [19:0] inc;
    logic [19:0] buf_inc;
    logic        en;
    logic        output_invert;
    logic        pulse_mode_sel;
    logic [2:0]  pulse_width_sel;
    logic [3:0]  clock_source_sel;
    logic        flag;
    logic        irq_en;
    logic [1:0]  arm;
    logic        pend;
    logic        pend_wr;
    logic [10:0] pidx;
    logic        ready;
    logic [31:0] rdata;
    logic        irq;
    logic        keep_osc;
  } pao_hub_t;
  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic        prev;
    logic        tick;
  } pao_edge_t;
  typedef struct packed {
    logic       lvl;
    logic [7:0] cnt;
    logic       out;
  } pao_shape_t;
endpackage : pao_pkg

// *** hdl/pao_shaper.sv ***
// output stage: fixed-duty toggle or timed pulse, then polarity
`timescale 1ns/1ps
`include "pao_defs.svh"
module pao_shaper (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  pao_core_if.shaper cif
);
  pao_pkg::pao_shape_t r;
  pao_pkg::pao_shape_t n;
  // ****************************************
  // output level and width counter
  // ****************************************
  always_comb begin
    n = r;
    if (!cif.en) begin
      n.lvl = 1'b0;
      n.cnt = '0;
    end else if (cif.tick) begin
      if (cif.carry) begin
        if (cif.pulse_mode) begin
          n.lvl = 1'b1;
          n.cnt = `PAO_CNT_ONE << cif.pulse_width_sel;
        end else begin
          n.lvl = ~r.lvl;
        end
      end else if (cif.pulse_mode && r.lvl) begin
        if (r.cnt <= `PAO_CNT_ONE) begin
          n.lvl = 1'b0;
        end else begin
          n.cnt = r.cnt - `PAO_CNT_ONE;
        end
      end
    end
    n.out = n.lvl ^ cif.output_invert;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign cif.out_lvl = r.out;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_fdc_toggle;
    (cif.en && cif.tick && cif.carry && !cif.pulse_mode) |=> (r.lvl != $past(r.lvl));
  endproperty
  a_fdc_toggle: assert property (p_fdc_toggle) else $error("fixed duty output did not toggle");
  property p_pf_start;
    (cif.en && cif.tick && cif.carry && cif.pulse_mode) |=> r.lvl;
  endproperty
  a_pf_start: assert property (p_pf_start) else $error("pulse did not start on overflow");
  property p_pol_out;
    cif.en |=> (r.out == (r.lvl ^ $past(cif.output_invert)));
  endproperty
  a_pol_out: assert property (p_pol_out) else $error("output polarity wrong");
endmodule : pao_shaper

// *** hdl/pao_top.sv ***
// phase accumulator oscillator: registers, accumulator, increment buffer, flag
//
// Notes on behaviour
// - 20-bit accumulator readable and writable as low, high and upper bytes.
// - each selected-clock rising edge adds the buffered increment to the accumulator.
// - adder carry is the raw overflow event; rate is clock times step over 2^20.
// - 20-bit step held in low, high, upper byte registers, all read/write.
// - enabled: low step write loads whole buffer on second selected-clock edge.
// - disabled: buffer follows written step at once; buffer is not visible.
// - mode clear: output toggles on every overflow, 50% duty.
// - mode set: output goes active after overflow, inactive 1 to 128 periods later.
// - width field gives two to the field value periods, 1 up to 128.
// - width field matters only in pulse mode.
// - pulse longer than overflow interval leaves output steady active.
// - control bit 4 inverts the final output; clear means active high.
// - polarity change with the block and interrupts enabled raises the flag.
// - every overflow sets the flag; software clears it; service needs enables.
// - any reset clears every register to zero.
// - control bit 7 enables the block.
// - control bit 5 reads the present output level.
// - control bit 0 selects pulse mode, clear selects fixed duty.
// - 4-bit source field; 1111 and 1010 reserved, 0000 system clock.
// - keeps counting in sleep; fast oscillator held on while selected and enabled.
`timescale 1ns/1ps
`include "pao_defs.svh"
module pao_top (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic [15:0] src_clk_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             nco_out_o,
  output logic             irq_o,
  output logic             keep_fast_osc_o
);
  pao_pkg::pao_hub_t r;
  pao_pkg::pao_hub_t n;
  pao_core_if        cif ();
  logic [20:0]       sum_w;
  logic [19:0]       acc_sum;
  logic              carry_w;
  logic              wr_now;
  logic [7:0]        wbyte;
  logic              hsize_unused;

  // ****************************************
  // address decode helper
  // ****************************************
  function automatic logic pao_hit(input logic [10:0] a, input logic [10:0] idx);
    pao_hit = (a == idx);
  endfunction : pao_hit

  // ****************************************
  // sub blocks
  // ****************************************
  pao_edge_pick u_edge (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .src_clk_i (src_clk_i),
    .cif       (cif.edger)
  );
  pao_shaper u_shape (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .cif       (cif.shaper)
  );

  // ****************************************
  // adder and carry
  // ****************************************
  assign sum_w        = {1'b0, r.acc} + {1'b0, r.buf_inc};
  assign acc_sum      = sum_w[19:0];
  assign carry_w      = cif.tick & r.en & sum_w[20];
  assign wr_now       = r.pend & r.pend_wr;
  assign wbyte        = hwdata_i[`PAO_BYTE];
  assign hsize_unused = ^hsize_i;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n       = r;
    n.ready = 1'b1;
    // accumulate on each selected edge
    if (cif.tick && r.en) begin
      n.acc = acc_sum;
    end
    // double buffered step
    if (!r.en) begin
      n.buf_inc = r.inc;
      n.arm     = `PAO_ARM_IDLE;
    end else if (cif.tick && r.arm == `PAO_ARM_WRITE) begin
      n.arm = `PAO_ARM_LAST;
    end else if (cif.tick && r.arm == `PAO_ARM_LAST) begin
      n.buf_inc = r.inc;
      n.arm     = `PAO_ARM_IDLE;
    end
    // data phase: one wait state, then answer
    if (r.pend) begin
      n.pend  = 1'b0;
      n.rdata = `PAO_RDATA_ZERO;
      if (r.pend_wr) begin
        if (pao_hit(r.pidx, `PAO_IDX_ACCL)) begin
          n.acc[`PAO_ACC_LO] = wbyte;
        end else if (pao_hit(r.pidx, `PAO_IDX_ACCH)) begin
          n.acc[`PAO_ACC_MID] = wbyte;
        end else if (pao_hit(r.pidx, `PAO_IDX_ACCU)) begin
          n.acc[`PAO_ACC_UP] = hwdata_i[`PAO_NIB];
        end else if (pao_hit(r.pidx, `PAO_IDX_INCL)) begin
          n.inc[`PAO_ACC_LO] = wbyte;
          if (r.en) begin
            n.arm = `PAO_ARM_WRITE;
          end
        end else if (pao_hit(r.pidx, `PAO_IDX_INCH)) begin
          n.inc[`PAO_ACC_MID] = wbyte;
        end else if (pao_hit(r.pidx, `PAO_IDX_INCU)) begin
          n.inc[`PAO_ACC_UP] = hwdata_i[`PAO_NIB];
        end else if (pao_hit(r.pidx, `PAO_IDX_CON)) begin
          n.en  = hwdata_i[`PAO_CON_EN];
          n.output_invert = hwdata_i[`PAO_CON_POL];
          n.pulse_mode_sel = hwdata_i[`PAO_CON_PFM];
        end else if (pao_hit(r.pidx, `PAO_IDX_CLK)) begin
          n.pulse_width_sel = hwdata_i[`PAO_CLK_PWS];
          n.clock_source_sel = hwdata_i[`PAO_CLK_CKS];
        end else if (pao_hit(r.pidx, `PAO_IDX_IRQ)) begin
          n.irq_en = hwdata_i[`PAO_IRQ_ENA];
          if (!hwdata_i[`PAO_IRQ_FLAG]) begin
            n.flag = 1'b0;
          end
        end
      end else begin
        if (pao_hit(r.pidx, `PAO_IDX_ACCL)) begin
          n.rdata[`PAO_BYTE] = r.acc[`PAO_ACC_LO];
        end else if (pao_hit(r.pidx, `PAO_IDX_ACCH)) begin
          n.rdata[`PAO_BYTE] = r.acc[`PAO_ACC_MID];
        end else if (pao_hit(r.pidx, `PAO_IDX_ACCU)) begin
          n.rdata[`PAO_NIB] = r.acc[`PAO_ACC_UP];
        end else if (pao_hit(r.pidx, `PAO_IDX_INCL)) begin
          n.rdata[`PAO_BYTE] = r.inc[`PAO_ACC_LO];
        end else if (pao_hit(r.pidx, `PAO_IDX_INCH)) begin
          n.rdata[`PAO_BYTE] = r.inc[`PAO_ACC_MID];
        end else if (pao_hit(r.pidx, `PAO_IDX_INCU)) begin
          n.rdata[`PAO_NIB] = r.inc[`PAO_ACC_UP];
        end else if (pao_hit(r.pidx, `PAO_IDX_CON)) begin
          n.rdata[`PAO_CON_EN]  = r.en;
          n.rdata[`PAO_CON_OUT] = cif.out_lvl;
          n.rdata[`PAO_CON_POL] = r.output_invert;
          n.rdata[`PAO_CON_PFM] = r.pulse_mode_sel;
        end else if (pao_hit(r.pidx, `PAO_IDX_CLK)) begin
          n.rdata[`PAO_CLK_PWS] = r.pulse_width_sel;
          n.rdata[`PAO_CLK_CKS] = r.clock_source_sel;
        end else if (pao_hit(r.pidx, `PAO_IDX_IRQ)) begin
          n.rdata[`PAO_IRQ_FLAG] = r.flag;
          n.rdata[`PAO_IRQ_ENA]  = r.irq_en;
        end
      end
    end
    // address phase accepted
    if (hsel_i && htrans_i[1] && hready_i) begin
      n.pend    = 1'b1;
      n.pend_wr = hwrite_i;
      n.pidx    = haddr_i[`PAO_ADDR_HI:`PAO_ADDR_LO];
      n.ready   = 1'b0;
    end
    // flag: a set in the same cycle as a clear wins
    if (carry_w) begin
      n.flag = 1'b1;
    end
    if (wr_now && pao_hit(r.pidx, `PAO_IDX_CON) && r.en && r.irq_en
        && (hwdata_i[`PAO_CON_POL] != r.output_invert)) begin
      n.flag = 1'b1;
    end
    n.irq      = n.flag & n.irq_en & n.en;
    n.keep_osc = n.en & (n.clock_source_sel == `PAO_CKS_FAST);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cif.carry       = carry_w;
  assign cif.en          = r.en;
  assign cif.pulse_mode  = r.pulse_mode_sel;
  assign cif.output_invert         = r.output_invert;
  assign cif.pulse_width_sel         = r.pulse_width_sel;
  assign cif.clock_source_sel         = r.clock_source_sel;
  assign hrdata_o        = r.rdata;
  assign hreadyout_o     = r.ready;
  assign hresp_o         = r.rdata[0] & hsize_unused & 1'b0;
  assign nco_out_o       = cif.out_lvl;
  assign irq_o           = r.irq;
  assign keep_fast_osc_o = r.keep_osc;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_acc_add;
    (cif.tick && r.en && !wr_now) |=> (r.acc == $past(acc_sum));
  endproperty
  a_acc_add: assert property (p_acc_add) else $error("accumulator did not add step");
  property p_acc_hold;
    (!cif.tick && !wr_now) |=> $stable(r.acc);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved without a tick");
  property p_carry_flag;
    carry_w |=> r.flag;
  endproperty
  a_carry_flag: assert property (p_carry_flag) else $error("overflow did not set flag");
  sequence s_armed_write;
    wr_now && r.en && pao_hit(r.pidx, `PAO_IDX_INCL);
  endsequence
  property p_arm_hold;
    (r.en && r.arm == `PAO_ARM_WRITE) |=> $stable(r.buf_inc);
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("step buffer loaded too early");
  property p_arm_load;
    (r.en && cif.tick && r.arm == `PAO_ARM_LAST) |=> (r.buf_inc == $past(r.inc));
  endproperty
  a_arm_load: assert property (p_arm_load) else $error("step buffer not loaded on second edge");
  property p_arm_start;
    s_armed_write |=> (r.arm == `PAO_ARM_WRITE);
  endproperty
  a_arm_start: assert property (p_arm_start) else $error("low step write did not arm load");
  property p_dis_load;
    !r.en |=> (r.buf_inc == $past(r.inc));
  endproperty
  a_dis_load: assert property (p_dis_load) else $error("disabled buffer not following step");
  property p_out_read;
    (r.pend && !r.pend_wr && pao_hit(r.pidx, `PAO_IDX_CON)) |=> (hrdata_o[`PAO_CON_OUT] == $past(cif.out_lvl));
  endproperty
  a_out_read: assert property (p_out_read) else $error("output level read back wrong");
  property p_irq_out;
    (r.flag && r.irq_en && r.en) |-> irq_o;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt request missing");
  property p_keep_osc;
    (r.en && r.clock_source_sel == `PAO_CKS_FAST) |-> keep_fast_osc_o;
  endproperty
  a_keep_osc: assert property (p_keep_osc) else $error("fast oscillator hold missing");
  property p_bus_wait;
    (hsel_i && htrans_i[1] && hready_i) |=> (!hreadyout_o ##1 hreadyout_o);
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus answer not one wait state");

  // ****************************************
  // checks on reset, bus wait, accumulator wrap, flag, register access and outputs
  // ****************************************
  property p_rst_clear;
    disable iff (1'b0) !rstn_i |=> (r == '0);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset left state set");
  property p_pend_wait;
    r.pend |-> !hreadyout_o;
  endproperty
  a_pend_wait: assert property (p_pend_wait) else $error("ready high during wait state");

  property p_no_add_off;
    (!r.en && !wr_now) |=> $stable(r.acc);
  endproperty
  a_no_add_off: assert property (p_no_add_off) else $error("accumulator moved while disabled");
  property p_wrap;
    (carry_w && !wr_now) |=> (r.acc < $past(r.acc));
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow did not wrap");
  property p_no_wrap;
    (cif.tick && r.en && !carry_w && !wr_now) |=> (r.acc >= $past(r.acc));
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("accumulator wrapped without carry");

  property p_flag_hold;
    (r.flag && !wr_now) |=> r.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a clear");
  property p_flag_clear;
    (wr_now && pao_hit(r.pidx, `PAO_IDX_IRQ) && !hwdata_i[`PAO_IRQ_FLAG] && !carry_w)
      |=> !r.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");
  property p_pol_flag;
    (wr_now && pao_hit(r.pidx, `PAO_IDX_CON) && r.en && r.irq_en && (hwdata_i[`PAO_CON_POL] != r.output_invert))
      |=> r.flag;
  endproperty
  a_pol_flag: assert property (p_pol_flag) else $error("polarity change gave no flag");

  property p_en_write;
    (wr_now && pao_hit(r.pidx, `PAO_IDX_CON)) |=> (r.en == $past(hwdata_i[`PAO_CON_EN]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable bit not written");
  property p_acc_read;
    (r.pend && !r.pend_wr && pao_hit(r.pidx, `PAO_IDX_ACCL))
      |=> (hrdata_o[`PAO_BYTE] == $past(r.acc[`PAO_ACC_LO]));
  endproperty
  a_acc_read: assert property (p_acc_read) else $error("accumulator low byte read wrong");
  property p_inc_read;
    (r.pend && !r.pend_wr && pao_hit(r.pidx, `PAO_IDX_INCL))
      |=> (hrdata_o[`PAO_BYTE] == $past(r.inc[`PAO_ACC_LO]));
  endproperty
  a_inc_read: assert property (p_inc_read) else $error("step low byte read wrong");

  property p_disable_out;
    !r.en |=> (nco_out_o == $past(r.output_invert));
  endproperty
  a_disable_out: assert property (p_disable_out) else $error("disabled output not at idle level");
  sequence s_pulse_fire;
    carry_w && r.pulse_mode_sel;
  endsequence
  sequence s_short_fire;
    carry_w && r.pulse_mode_sel && (r.pulse_width_sel == 3'h0);
  endsequence
  sequence s_fire_then_tick;
    s_short_fire ##1 (cif.tick && !carry_w && r.en && r.pulse_mode_sel);
  endsequence
  property p_pulse_on;
    s_pulse_fire |=> (nco_out_o != $past(r.output_invert));
  endproperty
  a_pulse_on: assert property (p_pulse_on) else $error("pulse not active after overflow");
  property p_pulse_one;
    s_fire_then_tick |=> (nco_out_o == $past(r.output_invert));
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("shortest pulse longer than one period");

  property p_fdc_flip;
    (carry_w && !r.pulse_mode_sel && $stable(r.output_invert)) |=> (nco_out_o != $past(nco_out_o));
  endproperty
  a_fdc_flip: assert property (p_fdc_flip) else $error("fixed duty pin did not toggle");
  property p_keep_off;
    (r.clock_source_sel != `PAO_CKS_FAST) |-> !keep_fast_osc_o;
  endproperty
  a_keep_off: assert property (p_keep_off) else $error("fast oscillator held without selection");
endmodule : pao_top
